// File: verilog/wag_regs.svh
// Constants of the waveform address generator
`ifndef WAG_REGS_SVH
`define WAG_REGS_SVH

`define WAG_ACC_W 38
`define WAG_TBL_W 12
`define WAG_ADDR_W 16
`define WAG_LEN_W 17
`define WAG_DAT_W 16
`define WAG_SQUARE_LEN 17'h00002
`define WAG_ARB_MIN_LEN 17'h00004
`define WAG_ARB_MAX_LEN 17'h10000
`define WAG_TBL_LEN 17'h01000
`define WAG_ADDR_ZERO 16'h0000
`define WAG_UPPER_ZERO 4'h0
`define WAG_SCLK_MAX_HZ 40000000
`define WAG_SCLK_MIN_MHZ 100
`define WAG_FREQ_STEP_UHZ 100

`endif

// File: verilog/wag_pkg.sv
// Types shared by the waveform address generator
package wag_pkg;

  typedef enum logic [2:0] {
    WAG_SHAPE_SINE = 3'h0,
    WAG_SHAPE_COSINE = 3'h1,
    WAG_SHAPE_HAVERSINE = 3'h2,
    WAG_SHAPE_TRIANGLE = 3'h3,
    WAG_SHAPE_SINC = 3'h4,
    WAG_SHAPE_RAMP = 3'h5,
    WAG_SHAPE_SQUARE = 3'h6,
    WAG_SHAPE_SEQ = 3'h7
  } wag_shape_t;

  typedef enum logic [1:0] {
    WAG_ST_IDLE = 2'h0,
    WAG_ST_DDS = 2'h1,
    WAG_ST_CLK = 2'h2,
    WAG_ST_HOLD = 2'h3
  } wag_state_t;

endpackage

// File: verilog/wag_sample_reg.sv
// Output register that forwards or freezes the addressed sample
`timescale 1ns/100ps
`default_nettype none
`include "wag_regs.svh"

module wag_sample_reg (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [`WAG_DAT_W-1:0] din,
  output logic [`WAG_DAT_W-1:0] dout
);
  import wag_pkg::*;

  typedef struct packed {
    logic [`WAG_DAT_W-1:0] dat;
  } wag_sreg_t;

  wag_sreg_t cur_ff;
  wag_sreg_t nxt_cur;

  always_comb begin
    nxt_cur = cur_ff;
    if (load) begin
      nxt_cur.dat = din;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign dout = cur_ff.dat;
endmodule // wag_sample_reg

`default_nettype wire

// File: verilog/wag_addr_gen.sv
// Waveform RAM address generator: phase accumulator and sequential counter
// Notes on behaviour
// - Sine, cosine, haversine, triangle, sinc and ramp use the phase accumulator unless pulse_shape is set, others count.
// - Both modes step RAM addresses and forward each sample to the converter in order.
// - In counting mode the address rises by one on each sample clock tick.
// - The counter wraps to zero after the last point so a period equals the length.
// - Wrap length is 4 to 65536 for arbitrary, 2 for square, set by period for pulses.
// - One accumulator cycle spans 4096 table entries.
// - The loaded increment is added to the accumulator on every clock in the DDS state except the one that enters hold.
// - The top 12 accumulator bits drive the low address lines, the upper 4 stay zero.
// - The accumulator is 38 bits wide.
// - A new increment takes effect from the next clock on.
// - Small increments repeat addresses and large ones skip them.
// - A pause request freezes playback, sweep and the output sample.
`timescale 1ns/100ps
`default_nettype none
`include "wag_regs.svh"

module wag_addr_gen (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire wag_pkg::wag_shape_t shape,
  input wire logic pulse_shape,
  input wire logic [`WAG_LEN_W-1:0] arb_len,
  input wire logic [`WAG_LEN_W-1:0] pulse_len,
  input wire logic [`WAG_ACC_W-1:0] phase_inc,
  input wire logic inc_load,
  input wire logic sample_tick,
  input wire logic manual_pause_request,
  input wire logic [`WAG_DAT_W-1:0] ram_data,
  output logic [`WAG_ADDR_W-1:0] ram_addr,
  output logic [`WAG_DAT_W-1:0] dac_data,
  output logic dds_mode,
  output logic paused,
  output logic sweep_enable
);
  import wag_pkg::*;

  typedef struct packed {
    wag_state_t st;
    logic [`WAG_ACC_W-1:0] inc;
    logic [`WAG_ACC_W-1:0] acc;
    logic [`WAG_LEN_W-1:0] cnt;
    logic [`WAG_ADDR_W-1:0] addr;
    logic fwd;
    logic pause_s1;
    logic pause_s2;
    logic tick_s1;
    logic tick_s2;
    logic tick_s3;
  } wag_state_s_t;

  wag_state_s_t cur_ff;
  wag_state_s_t nxt_cur;
  logic use_dds;
  logic [`WAG_LEN_W-1:0] wrap_len;
  logic tick_rise;

  ////////////////////////////////////////////////////////////////
  // Mode and length selection

  always_comb begin
    use_dds = 1'b0;
    case (shape)
      WAG_SHAPE_SINE, WAG_SHAPE_COSINE, WAG_SHAPE_HAVERSINE,
      WAG_SHAPE_TRIANGLE, WAG_SHAPE_SINC, WAG_SHAPE_RAMP: begin
        use_dds = ~pulse_shape;
      end
      default: begin
        use_dds = 1'b0;
      end
    endcase
  end

  always_comb begin
    if (shape == WAG_SHAPE_SQUARE && !pulse_shape) begin
      wrap_len = `WAG_SQUARE_LEN;
    end else if (pulse_shape) begin
      wrap_len = (pulse_len < `WAG_SQUARE_LEN) ? `WAG_SQUARE_LEN : pulse_len;
    end else if (arb_len < `WAG_ARB_MIN_LEN) begin
      wrap_len = `WAG_ARB_MIN_LEN;
    end else if (arb_len > `WAG_ARB_MAX_LEN) begin
      wrap_len = `WAG_ARB_MAX_LEN;
    end else begin
      wrap_len = arb_len;
    end
  end

  assign tick_rise = cur_ff.tick_s2 & ~cur_ff.tick_s3;

  ////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.pause_s1 = manual_pause_request;
    nxt_cur.pause_s2 = cur_ff.pause_s1;
    nxt_cur.tick_s1 = sample_tick;
    nxt_cur.tick_s2 = cur_ff.tick_s1;
    nxt_cur.tick_s3 = cur_ff.tick_s2;
    nxt_cur.fwd = 1'b0;
    if (inc_load) begin
      nxt_cur.inc = phase_inc;
    end
    case (cur_ff.st)
      WAG_ST_IDLE: begin
        nxt_cur.acc = '0;
        nxt_cur.cnt = '0;
        nxt_cur.addr = `WAG_ADDR_ZERO;
        if (run) begin
          nxt_cur.st = use_dds ? WAG_ST_DDS : WAG_ST_CLK;
        end
      end
      WAG_ST_DDS: begin
        nxt_cur.acc = cur_ff.acc + cur_ff.inc;
        nxt_cur.addr = {`WAG_UPPER_ZERO, cur_ff.acc[`WAG_ACC_W-1 -: `WAG_TBL_W]};
        nxt_cur.fwd = 1'b1;
        if (!run || !use_dds) begin
          nxt_cur.st = WAG_ST_IDLE;
        end else if (cur_ff.pause_s2) begin
          nxt_cur.st = WAG_ST_HOLD;
          nxt_cur.acc = cur_ff.acc;
          nxt_cur.fwd = 1'b0;
        end
      end
      WAG_ST_CLK: begin
        if (!run || use_dds) begin
          nxt_cur.st = WAG_ST_IDLE;
        end else if (cur_ff.pause_s2) begin
          nxt_cur.st = WAG_ST_HOLD;
        end else if (tick_rise) begin
          nxt_cur.addr = cur_ff.cnt[`WAG_ADDR_W-1:0];
          nxt_cur.fwd = 1'b1;
          if (cur_ff.cnt + 17'h00001 >= wrap_len) begin
            nxt_cur.cnt = '0;
          end else begin
            nxt_cur.cnt = cur_ff.cnt + 17'h00001;
          end
        end
      end
      WAG_ST_HOLD: begin
        if (!run) begin
          nxt_cur.st = WAG_ST_IDLE;
        end else if (!cur_ff.pause_s2) begin
          nxt_cur.st = use_dds ? WAG_ST_DDS : WAG_ST_CLK;
        end
      end
      default: begin
        nxt_cur.st = WAG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Sample forwarding

  wag_sample_reg u_sample (
    .clk(clk),
    .sys_rst(sys_rst),
    .load(cur_ff.fwd),
    .din(ram_data),
    .dout(dac_data)
  );

  assign ram_addr = cur_ff.addr;
  assign dds_mode = (cur_ff.st == WAG_ST_DDS);
  assign paused = (cur_ff.st == WAG_ST_HOLD);
  assign sweep_enable = (cur_ff.st == WAG_ST_DDS) & ~cur_ff.pause_s2;

  ////////////////////////////////////////////////////////////////
  // Checks

  sequence dds_step_s;
    cur_ff.st == WAG_ST_DDS && nxt_cur.st == WAG_ST_DDS;
  endsequence

  acc_adds_inc_a: assert property (@(posedge clk) disable iff (sys_rst)
    dds_step_s |=> cur_ff.acc == $past(cur_ff.acc) + $past(cur_ff.inc))
    else $error("accumulator did not add increment");

  upper_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    dds_step_s |=> ram_addr[`WAG_ADDR_W-1:`WAG_TBL_W] == `WAG_UPPER_ZERO)
    else $error("upper address lines not zero");

  top_bits_a: assert property (@(posedge clk) disable iff (sys_rst)
    dds_step_s |=> ram_addr[`WAG_TBL_W-1:0] == $past(cur_ff.acc[`WAG_ACC_W-1 -: `WAG_TBL_W]))
    else $error("table address not from accumulator top");

  inc_next_a: assert property (@(posedge clk) disable iff (sys_rst)
    inc_load |=> cur_ff.inc == $past(phase_inc))
    else $error("increment not applied next clock");

  clk_step_a: assert property (@(posedge clk) disable iff (sys_rst)
    cur_ff.st == WAG_ST_CLK && nxt_cur.st == WAG_ST_CLK && tick_rise
      && cur_ff.cnt + 17'h00001 < wrap_len |=> cur_ff.cnt == $past(cur_ff.cnt) + 17'h00001)
    else $error("counter did not step by one");

  clk_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
    cur_ff.st == WAG_ST_CLK && nxt_cur.st == WAG_ST_CLK && tick_rise
      && cur_ff.cnt + 17'h00001 >= wrap_len |=> cur_ff.cnt == '0)
    else $error("counter did not wrap");

  square_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    shape == WAG_SHAPE_SQUARE && !pulse_shape |-> wrap_len == `WAG_SQUARE_LEN)
    else $error("square length not two");

  hold_freeze_a: assert property (@(posedge clk) disable iff (sys_rst)
    paused ##1 paused |-> $stable(dac_data) && $stable(ram_addr))
    else $error("output moved during hold");

  fwd_order_a: assert property (@(posedge clk) disable iff (sys_rst)
    cur_ff.fwd |=> dac_data == $past(ram_data))
    else $error("sample not forwarded");

  dds_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
    dds_mode |-> $past(use_dds))
    else $error("wrong synthesis mode");

  ////////////////////////////////////////////////////////////////
  // Checks on holding, counting and accumulator upkeep

  sequence clk_tick_s;
    cur_ff.st == WAG_ST_CLK && nxt_cur.st == WAG_ST_CLK && tick_rise;
  endsequence

  sequence hold_s;
    paused && nxt_cur.st == WAG_ST_HOLD;
  endsequence

  sequence pause_seen_s;
    cur_ff.pause_s2 && run
      && ((cur_ff.st == WAG_ST_DDS && use_dds) || (cur_ff.st == WAG_ST_CLK && !use_dds));
  endsequence

  sequence resume_s;
    paused && !cur_ff.pause_s2 && run;
  endsequence

  inc_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    !inc_load |=> $stable(cur_ff.inc))
    else $error("increment changed without load");

  acc_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
    dds_step_s and (cur_ff.acc + cur_ff.inc) < cur_ff.acc |=> cur_ff.acc < $past(cur_ff.acc))
    else $error("accumulator did not roll over");

  dds_fwd_a: assert property (@(posedge clk) disable iff (sys_rst)
    dds_step_s |=> cur_ff.fwd)
    else $error("accumulator step not forwarded");

  dds_cnt_a: assert property (@(posedge clk) disable iff (sys_rst)
    cur_ff.st == WAG_ST_DDS |=> $stable(cur_ff.cnt))
    else $error("counter moved in accumulator mode");

  idle_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
    cur_ff.st == WAG_ST_IDLE |=> ram_addr == `WAG_ADDR_ZERO)
    else $error("idle address not first point");

  wrap_range_a: assert property (@(posedge clk) disable iff (sys_rst)
    shape != WAG_SHAPE_SQUARE && !pulse_shape
      |-> wrap_len >= `WAG_ARB_MIN_LEN && wrap_len <= `WAG_ARB_MAX_LEN)
    else $error("arbitrary length out of range");

  clk_addr_a: assert property (@(posedge clk) disable iff (sys_rst)
    clk_tick_s |=> ram_addr == $past(cur_ff.cnt[`WAG_ADDR_W-1:0]) && cur_ff.fwd)
    else $error("count not presented as address");

  clk_idle_cnt_a: assert property (@(posedge clk) disable iff (sys_rst)
    cur_ff.st == WAG_ST_CLK && !tick_rise |=> $stable(cur_ff.cnt))
    else $error("counter moved without sample clock");

  rise_once_a: assert property (@(posedge clk) disable iff (sys_rst)
    tick_rise |=> !tick_rise)
    else $error("one sample clock gave two steps");

  hold_state_a: assert property (@(posedge clk) disable iff (sys_rst)
    hold_s |=> $stable(cur_ff.acc) && $stable(cur_ff.cnt))
    else $error("playback moved during hold");

  hold_no_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    paused |-> !cur_ff.fwd)
    else $error("sample loaded during hold");

  sweep_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    paused |-> !sweep_enable)
    else $error("sweep enabled during hold");

  pause_enter_a: assert property (@(posedge clk) disable iff (sys_rst)
    pause_seen_s |=> paused)
    else $error("hold not entered");

  resume_a: assert property (@(posedge clk) disable iff (sys_rst)
    resume_s |=> !paused && dds_mode == $past(use_dds))
    else $error("hold not left to current mode");
endmodule // wag_addr_gen

`default_nettype wire

// File: test/wag_ram_model.sv
// Combinational waveform sample RAM model
`timescale 1ns/100ps
`default_nettype none
`include "wag_regs.svh"

module wag_ram_model (
  input wire logic [`WAG_ADDR_W-1:0] ram_addr,
  output logic [`WAG_DAT_W-1:0] ram_data
);
  // Distinct word per address so order faults show
  assign ram_data = ram_addr ^ 16'ha5c3;
endmodule // wag_ram_model
`default_nettype wire

// File: test/waveform_address_generator_bench.sv
// Self-checking bench for the waveform address generator
`timescale 1ns/100ps
`default_nettype none

module waveform_address_generator_bench;
  import wag_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic run = 1'b0;
  wag_shape_t shape = WAG_SHAPE_SINE;
  logic pulse_shape = 1'b0;
  logic [16:0] arb_len = 17'h00004;
  logic [16:0] pulse_len = 17'h00003;
  logic [37:0] phase_inc = 38'h0;
  logic inc_load = 1'b0;
  logic sample_tick = 1'b0;
  logic mpr = 1'b0;
  logic [15:0] ram_data, ram_addr, dac_data;
  logic dds_mode, paused, sweep_enable;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;

  always #20 clk = ~clk;

  wag_addr_gen u_dut (.clk(clk), .sys_rst(sys_rst), .run(run), .shape(shape),
    .pulse_shape(pulse_shape), .arb_len(arb_len), .pulse_len(pulse_len),
    .phase_inc(phase_inc), .inc_load(inc_load), .sample_tick(sample_tick),
    .manual_pause_request(mpr), .ram_data(ram_data), .ram_addr(ram_addr),
    .dac_data(dac_data), .dds_mode(dds_mode), .paused(paused),
    .sweep_enable(sweep_enable));
  wag_ram_model u_ram (.ram_addr(ram_addr), .ram_data(ram_data));

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Mode changes pass through idle
  task automatic start(input wag_shape_t s, input logic p);
    run = 1'b0;
    tk(2);
    shape = s;
    pulse_shape = p;
    run = 1'b1;
    tk(4);
  endtask

  task automatic load_inc(input logic [37:0] v);
    phase_inc = v;
    inc_load = 1'b1;
    tk(1);
    inc_load = 1'b0;
    tk(1);
  endtask

  // Address moves by step per gap, sample follows one edge behind
  task automatic dds_steps(input int n, input int gap, input logic [15:0] step);
    logic [15:0] prev;
    prev = ram_addr;
    repeat (n) begin
      tk(gap);
      chk("ram_addr", (prev + step) & 16'h0fff, ram_addr);
      if (gap == 1) chk("dac_data", prev ^ 16'ha5c3, dac_data);
      prev = ram_addr;
    end
  endtask

  task automatic cnt_seq(input int len);
    for (int i = 0; i < 2 * len; i++) begin
      sample_tick = 1'b1;
      tk(3);
      sample_tick = 1'b0;
      tk(3);
      chk("cnt_addr", 16'(i % len), ram_addr);
      chk("cnt_dac", 16'(i % len) ^ 16'ha5c3, dac_data);
    end
  endtask

  task automatic hold_check;
    logic [15:0] a, d;
    mpr = 1'b1;
    tk(4);
    chk("paused", 16'h1, {15'h0, paused});
    chk("sweep_enable", 16'h0, {15'h0, sweep_enable});
    a = ram_addr;
    d = dac_data;
    tk(10);
    chk("held_addr", a, ram_addr);
    chk("held_dac", d, dac_data);
    mpr = 1'b0;
    tk(4);
    chk("paused", 16'h0, {15'h0, paused});
    dds_steps(10, 1, 16'h0003);
  endtask

  initial begin
    tk(6);
    sys_rst = 1'b0;
    chk("ram_addr", 16'h0, ram_addr);
    for (int s = 0; s < 8; s++) begin
      start(wag_shape_t'(s), 1'b0);
      chk("dds_mode", {15'h0, s < 6}, {15'h0, dds_mode});
    end
    load_inc(38'h0004000000);
    start(WAG_SHAPE_SINE, 1'b0);
    chk("sweep_enable", 16'h1, {15'h0, sweep_enable});
    dds_steps(20, 1, 16'h0001);
    load_inc(38'h0002000000);
    dds_steps(20, 2, 16'h0001);
    load_inc(38'h000c000000);
    dds_steps(1500, 1, 16'h0003);
    hold_check();
    start(WAG_SHAPE_SQUARE, 1'b0);
    cnt_seq(2);
    start(WAG_SHAPE_SEQ, 1'b0);
    cnt_seq(4);
    arb_len = 17'h00001;
    start(WAG_SHAPE_SEQ, 1'b0);
    cnt_seq(4);
    start(WAG_SHAPE_SEQ, 1'b1);
    cnt_seq(3);
    give_verdict();
  end
endmodule // waveform_address_generator_bench
`default_nettype wire
